/* rtl/fpcd_core.sv */
`timescale 1ns/1ps
`include "fpcd_defs.svh"
module fpcd_core #(
    parameter int LAT = `FPCD_FU_LATENCY
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // Coprocessor instruction bus
    input  wire logic         cop_valid_in,
    input  wire logic [1:0]   cop_op_in,
    input  wire logic [5:0]   cop_reg_in,
    input  wire logic [63:0]  cop_data_in,
    output logic              cop_ready_out,
    // Arithmetic instruction on address bus
    input  wire logic         alu_valid_in,
    input  wire logic [31:0]  alu_instr_in,
    output logic              alu_ready_out,
    // Data back to the CPU
    output logic [63:0]       rd_data_out,
    output logic              rd_valid_out,
    // Phase
    output logic [1:0]        phase_out
);
    // ==========================================
    // Arithmetic helpers
    function automatic logic [63:0] fp_pack(input logic s, input logic [13:0] e,
                                            input logic [51:0] f);
        if (e[13] || e == 14'h0000)
            return '0;
        if (e > 14'h07FF)
            return {s, {63{1'b1}}};
        return {s, e[10:0], f};
    endfunction

    function automatic logic [63:0] fp_mul(input logic [63:0] a, input logic [63:0] b);
        logic [105:0] m;
        logic [13:0]  e;
        logic [51:0]  f;
        m = {1'b1, a[51:0]} * {1'b1, b[51:0]};
        e = 14'(a[62:52]) + 14'(b[62:52]) - 14'(`FPCD_EXP_BIAS);
        f = m[104:53];
        if (!m[105])
        begin
            f = m[103:52];
            e = e - 14'h0001;
        end
        if (a[62:52] == 11'h000 || b[62:52] == 11'h000)
            return '0;
        return fp_pack(a[63] ^ b[63], e, f);
    endfunction

    function automatic logic [63:0] fp_add(input logic [63:0] a, input logic [63:0] b);
        logic [63:0] x;
        logic [63:0] y;
        logic [54:0] ms;
        logic [10:0] d;
        logic [13:0] e;
        int          p;
        x = (a[62:0] >= b[62:0]) ? a : b;
        y = (a[62:0] >= b[62:0]) ? b : a;
        p = 0;
        if (y[62:52] == 11'h000)
            return x;
        d = x[62:52] - y[62:52];
        ms = (d > 11'h036) ? 55'h0 : ({3'h1, y[51:0]} >> d);
        ms = (x[63] == y[63]) ? {3'h1, x[51:0]} + ms : {3'h1, x[51:0]} - ms;
        if (ms == '0)
            return '0;
        for (int i = 0; i < 55; i++)
            if (ms[i])
                p = i;
        e = 14'(x[62:52]) + 14'(p) - 14'h0034;
        ms = (p > 52) ? ms >> (p - 52) : ms << (52 - p);
        return fp_pack(x[63], e, ms[51:0]);
    endfunction

    function automatic logic [63:0] fp_float(input logic [31:0] v);
        logic [31:0] mag;
        logic [52:0] m;
        int          p;
        mag = v[31] ? (~v + 32'h1) : v;
        p = 0;
        for (int i = 0; i < 32; i++)
            if (mag[i])
                p = i;
        m = 53'(mag) << (52 - p);
        if (mag == '0)
            return '0;
        return fp_pack(v[31], 14'(p) + 14'h0401, m[51:0]);
    endfunction

    function automatic logic [31:0] fp_trunc(input logic [63:0] a);
        logic [52:0] m;
        int          k;
        k = int'(a[62:52]) - `FPCD_EXP_BIAS;
        if (a[62:52] == 11'h000 || k <= 0)
            return '0;
        if (k > 31)
            return a[63] ? 32'h8000_0000 : 32'h7FFF_FFFF;
        m = {1'b1, a[51:0]} >> (53 - k);
        return a[63] ? (~m[31:0] + 32'h1) : m[31:0];
    endfunction

    // Only the top 16 fraction bits feed the divider: small, and enough for seeding
    function automatic logic [63:0] fp_recip(input logic [63:0] a);
        logic [33:0] q;
        logic [13:0] e;
        q = 34'h2_0000_0000 / 34'({1'b1, a[51:36]});
        e = 14'h0801 - 14'(a[62:52]);
        if (a[62:52] == 11'h000)
            return '0;
        if (q[17])
            return fp_pack(a[63], e + 14'h0001, 52'h0);
        return fp_pack(a[63], e, {q[15:0], 36'h0});
    endfunction

    // ==========================================
    // Phase divider
    logic [3:0]  tick_cnt_reg;
    logic [1:0]  phase_reg;
    logic        phase_tick;
    logic        cyc_en;

    assign phase_tick = (tick_cnt_reg == 4'(`FPCD_PHASE_CLKS - 1));
    assign cyc_en     = phase_tick && phase_reg == 2'(`FPCD_PHASES - 1);

    always_ff @(posedge clk_in)
    begin
        if (srst_in || phase_tick)
            tick_cnt_reg <= 4'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            phase_reg <= 2'h0;
        else if (phase_tick)
            phase_reg <= phase_reg + 2'h1;
    end

    // ==========================================
    // Instruction registers and scoreboard
    fpcd_rf_if                 rf_bus ();
    logic [31:0]               alu_ir_reg;
    logic                      alu_ir_valid_reg;
    logic [1:0]                cop_op_reg;
    logic [5:0]                cop_reg_reg;
    logic [63:0]               cop_data_reg;
    logic                      cop_ir_valid_reg;
    logic [`FPCD_GPR_COUNT-1:0] pending_reg;
    logic [5:0]                alu_dst;
    logic [5:0]                alu_sa;
    logic [5:0]                alu_sb;
    logic                      alu_hazard;
    logic                      cop_hazard;
    logic                      alu_take;
    logic                      cop_take;
    logic                      issue_fire;
    logic                      cop_exec;
    logic                      wb_fire;

    function automatic logic busy(input logic [`FPCD_GPR_COUNT-1:0] pend, input logic [5:0] r);
        return (r < 6'(`FPCD_GPR_COUNT)) && pend[r];
    endfunction

    assign alu_dst    = alu_ir_reg[`FPCD_DST_MSB:`FPCD_DST_LSB];
    assign alu_sa     = alu_ir_reg[`FPCD_SA_MSB:`FPCD_SA_LSB];
    assign alu_sb     = alu_ir_reg[`FPCD_SB_MSB:`FPCD_SB_LSB];
    assign alu_hazard = busy(pending_reg, alu_sa) || busy(pending_reg, alu_sb)
                        || busy(pending_reg, alu_dst);
    assign cop_hazard = busy(pending_reg, cop_reg_reg);
    // Ignore instructions aimed at other coprocessors
    assign alu_take   = cyc_en && alu_valid_in && alu_ready_out
                        && alu_instr_in[`FPCD_DST_MSB:`FPCD_DST_LSB] <= `FPCD_ADDR_TIMER;
    assign cop_take   = cyc_en && cop_valid_in && cop_ready_out
                        && cop_reg_in < 6'(`FPCD_GPR_COUNT);
    assign issue_fire = cyc_en && alu_ir_valid_reg && !alu_hazard;
    assign cop_exec   = cyc_en && cop_ir_valid_reg && !cop_hazard;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            alu_ir_valid_reg <= 1'b0;
        else if (alu_take)
            alu_ir_valid_reg <= 1'b1;
        else if (issue_fire)
            alu_ir_valid_reg <= 1'b0;
        if (alu_take)
            alu_ir_reg <= alu_instr_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            cop_ir_valid_reg <= 1'b0;
        else if (cop_take)
            cop_ir_valid_reg <= 1'b1;
        else if (cop_exec)
            cop_ir_valid_reg <= 1'b0;
        if (cop_take)
        begin
            cop_op_reg   <= cop_op_in;
            cop_reg_reg  <= cop_reg_in;
            cop_data_reg <= cop_data_in;
        end
    end

    // State moves only on cycle ends, so a one-clock-late ready is exact there
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            alu_ready_out <= 1'b0;
            cop_ready_out <= 1'b0;
        end
        else
        begin
            alu_ready_out <= !alu_ir_valid_reg || (!alu_hazard && !cyc_en);
            cop_ready_out <= !cop_ir_valid_reg || (!cop_hazard && !cyc_en);
        end
    end

    // ==========================================
    // Operands and units
    fpcd_pkg::fpcd_word_t opa;
    fpcd_pkg::fpcd_word_t opb;
    fpcd_pkg::fpcd_word_t prod;
    fpcd_pkg::fpcd_word_t result;
    logic [31:0]          imul_lo;

    function automatic logic [63:0] operand(input logic [5:0] sel, input logic [63:0] rd);
        if (sel < 6'(`FPCD_GPR_COUNT))
            return rd;
        if (sel == `FPCD_ADDR_CLOCK)
            return `FPCD_CONST_HALF;
        if (sel == `FPCD_ADDR_TIMER)
            return `FPCD_CONST_ONE;
        return `FPCD_CONST_ZERO;
    endfunction

    assign opa     = operand(alu_sa, rf_bus.ra_data);
    assign opb     = operand(alu_sb, rf_bus.rb_data);
    assign prod    = fp_mul(opa, opb);
    assign imul_lo = opa[63:32] * opb[63:32];

    // Integer forms use the high word only
    always_comb
    begin
        unique case (fpcd_pkg::fpcd_alu_op_t'(alu_ir_reg[`FPCD_OP_MSB:`FPCD_OP_LSB]))
            fpcd_pkg::FPCD_ADD:   result = fp_add(opa, opb);
            fpcd_pkg::FPCD_SUB:   result = fp_add(opa, {~opb[63], opb[62:0]});
            fpcd_pkg::FPCD_FLOAT: result = fp_float(opa[63:32]);
            fpcd_pkg::FPCD_TRUNC: result = {fp_trunc(opa), 32'h0};
            fpcd_pkg::FPCD_MUL:   result = prod;
            fpcd_pkg::FPCD_IMUL:  result = {imul_lo, 32'h0};
            fpcd_pkg::FPCD_ITER:  result = fp_add(`FPCD_CONST_TWO, {~prod[63], prod[62:0]});
            fpcd_pkg::FPCD_RECIP: result = fp_recip(opa);
            default:              result = '0;
        endcase
    end

    // ==========================================
    // Shared result pipeline, one issue per cycle so one writeback per cycle
    logic                 pv_reg [LAT];
    logic [5:0]           pd_reg [LAT];
    fpcd_pkg::fpcd_word_t pr_reg [LAT];

    for (genvar s = 0; s < LAT; s++)
    begin : g_stage
        always_ff @(posedge clk_in)
        begin
            if (srst_in)
                pv_reg[s] <= 1'b0;
            else if (cyc_en)
            begin
                pv_reg[s] <= (s == 0) ? issue_fire : pv_reg[(s == 0) ? 0 : s - 1];
                pd_reg[s] <= (s == 0) ? alu_dst : pd_reg[(s == 0) ? 0 : s - 1];
                pr_reg[s] <= (s == 0) ? result : pr_reg[(s == 0) ? 0 : s - 1];
            end
        end
    end

    assign wb_fire = cyc_en && pv_reg[LAT-1];

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            pending_reg <= '0;
        else if (cyc_en)
        begin
            if (wb_fire && pd_reg[LAT-1] < 6'(`FPCD_GPR_COUNT))
                pending_reg[pd_reg[LAT-1]] <= 1'b0;
            if (issue_fire && alu_dst < 6'(`FPCD_GPR_COUNT))
                pending_reg[alu_dst] <= 1'b1;
        end
    end

    // ==========================================
    // Register file
    assign rf_bus.ra_addr = alu_sa;
    assign rf_bus.rb_addr = alu_sb;
    assign rf_bus.rm_addr = cop_reg_reg;
    assign rf_bus.wr_addr = pd_reg[LAT-1];
    assign rf_bus.wr_data = pr_reg[LAT-1];
    assign rf_bus.wr_en   = wb_fire && pd_reg[LAT-1] < 6'(`FPCD_GPR_COUNT);
    assign rf_bus.ld_addr = cop_reg_reg;
    assign rf_bus.ld_data = (cop_op_reg == fpcd_pkg::FPCD_TO_COP) ?
                            {cop_data_reg[63:32], 32'h0} : cop_data_reg;
    assign rf_bus.ld_en   = cop_exec && (cop_op_reg == fpcd_pkg::FPCD_LOAD
                            || cop_op_reg == fpcd_pkg::FPCD_TO_COP);

    fpcd_regfile #(
        .DEPTH (`FPCD_GPR_COUNT)
    ) u_regfile (
        .clk_in (clk_in),
        .rf     (rf_bus.mem)
    );

    // ==========================================
    // Store and transfer data out
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= '0;
        end
        else
        begin
            rd_valid_out <= cop_exec && (cop_op_reg == fpcd_pkg::FPCD_STORE
                            || cop_op_reg == fpcd_pkg::FPCD_FROM_COP);
            if (cop_exec && cop_op_reg == fpcd_pkg::FPCD_STORE)
                rd_data_out <= rf_bus.rm_data;
            else if (cop_exec && cop_op_reg == fpcd_pkg::FPCD_FROM_COP)
                rd_data_out <= {rf_bus.rm_data[63:32], 32'h0};
        end
    end

    assign phase_out = phase_reg;

    // ==========================================
    // Checks
    property p_cycle_spacing;
        @(posedge clk_in) disable iff (srst_in) cyc_en |=> !cyc_en [*3] ##1 cyc_en;
    endproperty
    a_cycle_spacing: assert property (p_cycle_spacing) else $error("cycle not 4 clocks");

    property p_phase_wrap;
        @(posedge clk_in) disable iff (srst_in) cyc_en |=> phase_out == 2'h0;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

    property p_latency;
        @(posedge clk_in) disable iff (srst_in) issue_fire |-> ##12 wb_fire;
    endproperty
    a_latency: assert property (p_latency) else $error("result not back in 3 cycles");

    property p_hold_on_hazard;
        @(posedge clk_in) disable iff (srst_in)
            (cyc_en && alu_ir_valid_reg && alu_hazard) |=> alu_ir_valid_reg && $stable(alu_ir_reg);
    endproperty
    a_hold_on_hazard: assert property (p_hold_on_hazard) else $error("hazard not held");

    property p_capture;
        @(posedge clk_in) disable iff (srst_in)
            alu_take |=> alu_ir_valid_reg && alu_ir_reg == $past(alu_instr_in);
    endproperty
    a_capture: assert property (p_capture) else $error("arith instr not captured");

    property p_pending_set;
        @(posedge clk_in) disable iff (srst_in)
            (issue_fire && alu_dst < 6'h34) |=> pending_reg[$past(alu_dst)];
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("pending not set");

    property p_store_answer;
        @(posedge clk_in) disable iff (srst_in)
            (cop_exec && cop_op_reg == fpcd_pkg::FPCD_STORE) |=> rd_valid_out ##1 !rd_valid_out;
    endproperty
    a_store_answer: assert property (p_store_answer) else $error("store data missing");

    property p_full_rate;
        @(posedge clk_in) disable iff (srst_in)
            (issue_fire && alu_take) |=> pv_reg[0] && alu_ir_valid_reg;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("issue rate lost");
endmodule

/* rtl/fpcd_defs.svh */
`ifndef FPCD_DEFS_SVH
`define FPCD_DEFS_SVH
// Overview of operation
// - One arithmetic and one load/store per cycle
// - 40 ns cycle of four 10 ns phases
// - Float arithmetic in 64-bit double precision, integer forms in 32 bits
// - Sign, 11-bit exponent, 52-bit fraction
// - Two operand reads, two writes (result and load), one extra read
// - 52 general registers of 64 bits
// - Register file supplies constants 0, 1/2, 1
// - Adder: add, sub, float, trunc, 3 cycles
// - Multiplier: mul, integer mul, 2-A*B, 3 cycles
// - Reciprocal approximation to 16 bits, 3 cycles
// - Scoreboard and instruction registers govern issue
// - Load/store/transfer arrive on coprocessor bus
// - Arithmetic instructions arrive on address bus
// - Ownership decided by destination or source specifier
// - Addresses 52..54 read as constants, writes ignored

// ==========================================
// Timing
`define FPCD_CLK_NS      10
`define FPCD_PHASE_NS    10
`define FPCD_CYCLE_NS    40
`define FPCD_PHASE_CLKS  (`FPCD_PHASE_NS / `FPCD_CLK_NS)
`define FPCD_PHASES      (`FPCD_CYCLE_NS / `FPCD_PHASE_NS)
`define FPCD_FU_LATENCY  3

// ==========================================
// Register space
`define FPCD_GPR_COUNT   52
`define FPCD_ADDR_STATUS 6'h34
`define FPCD_ADDR_CLOCK  6'h35
`define FPCD_ADDR_TIMER  6'h36

// ==========================================
// Operand format and constants
`define FPCD_SIGN_BIT    63
`define FPCD_EXP_MSB     62
`define FPCD_EXP_LSB     52
`define FPCD_FRAC_MSB    51
`define FPCD_EXP_BIAS    1024
`define FPCD_CONST_ZERO  64'h0000_0000_0000_0000
`define FPCD_CONST_HALF  64'h4000_0000_0000_0000
`define FPCD_CONST_ONE   64'h4010_0000_0000_0000
`define FPCD_CONST_TWO   64'h4020_0000_0000_0000

// ==========================================
// Arithmetic instruction fields
`define FPCD_OP_MSB      31
`define FPCD_OP_LSB      28
`define FPCD_DST_MSB     27
`define FPCD_DST_LSB     22
`define FPCD_SA_MSB      21
`define FPCD_SA_LSB      16
`define FPCD_SB_MSB      15
`define FPCD_SB_LSB      10
`endif

/* rtl/fpcd_pkg.sv */
package fpcd_pkg;
    typedef logic [63:0] fpcd_word_t;
    typedef enum logic [3:0] {
        FPCD_ADD, FPCD_SUB, FPCD_FLOAT, FPCD_TRUNC,
        FPCD_MUL, FPCD_IMUL, FPCD_ITER, FPCD_RECIP
    } fpcd_alu_op_t;
    typedef enum logic [1:0] {
        FPCD_LOAD, FPCD_STORE, FPCD_TO_COP, FPCD_FROM_COP
    } fpcd_cop_op_t;
endpackage

/* rtl/fpcd_regfile.sv */
`timescale 1ns/1ps
`include "fpcd_defs.svh"
module fpcd_regfile #(
    parameter int DEPTH = `FPCD_GPR_COUNT
) (
    // Clock
    input  wire logic  clk_in,
    // Port bundle
    fpcd_rf_if.mem     rf
);
    fpcd_pkg::fpcd_word_t mem_reg [DEPTH];
    fpcd_pkg::fpcd_word_t ra_reg;
    fpcd_pkg::fpcd_word_t rb_reg;
    fpcd_pkg::fpcd_word_t rm_reg;

    // ==========================================
    // Storage, result write wins over load
    for (genvar e = 0; e < DEPTH; e++)
    begin : g_entry
        always_ff @(posedge clk_in)
        begin
            if (rf.wr_en && rf.wr_addr == 6'(e))
                mem_reg[e] <= rf.wr_data;
            else if (rf.ld_en && rf.ld_addr == 6'(e))
                mem_reg[e] <= rf.ld_data;
        end
    end

    // ==========================================
    // Three registered read ports
    always_ff @(posedge clk_in)
    begin
        ra_reg <= (rf.ra_addr < 6'(DEPTH)) ? mem_reg[rf.ra_addr] : '0;
        rb_reg <= (rf.rb_addr < 6'(DEPTH)) ? mem_reg[rf.rb_addr] : '0;
        rm_reg <= (rf.rm_addr < 6'(DEPTH)) ? mem_reg[rf.rm_addr] : '0;
    end

    assign rf.ra_data = ra_reg;
    assign rf.rb_data = rb_reg;
    assign rf.rm_data = rm_reg;
endmodule

/* rtl/fpcd_rf_if.sv */
`timescale 1ns/1ps
interface fpcd_rf_if;
    logic [5:0]               ra_addr;
    logic [5:0]               rb_addr;
    logic [5:0]               rm_addr;
    logic [5:0]               wr_addr;
    logic [5:0]               ld_addr;
    fpcd_pkg::fpcd_word_t     ra_data;
    fpcd_pkg::fpcd_word_t     rb_data;
    fpcd_pkg::fpcd_word_t     rm_data;
    fpcd_pkg::fpcd_word_t     wr_data;
    fpcd_pkg::fpcd_word_t     ld_data;
    logic                     wr_en;
    logic                     ld_en;
    modport core (output ra_addr, rb_addr, rm_addr, wr_addr, ld_addr, wr_data, ld_data,
                  wr_en, ld_en, input ra_data, rb_data, rm_data);
    modport mem (input ra_addr, rb_addr, rm_addr, wr_addr, ld_addr, wr_data, ld_data,
                 wr_en, ld_en, output ra_data, rb_data, rm_data);
endinterface

/* test/fpcd_host_model.sv */
`timescale 1ns/1ps
module fpcd_host_model (
    // Clock and status from the coprocessor
    input  wire logic        clk_in,
    input  wire logic [1:0]  phase_in,
    input  wire logic        cop_ready_in,
    input  wire logic        alu_ready_in,
    // Coprocessor instruction bus
    output logic             cop_valid_out,
    output logic [1:0]       cop_op_out,
    output logic [5:0]       cop_reg_out,
    output logic [63:0]      cop_data_out,
    // Arithmetic instruction on the address bus
    output logic             alu_valid_out,
    output logic [31:0]      alu_instr_out
);
    int stall_cnt = 0;

    initial
    begin
        cop_valid_out = 1'b0;
        cop_op_out = 2'h0;
        cop_reg_out = 6'h3f;
        cop_data_out = 64'hdead_beef_0bad_f00d;
        alu_valid_out = 1'b0;
        alu_instr_out = 32'hffff_ffff;
    end

    // =========================================
    // Requests held from a falling edge until the taking edge
    task automatic cop_send(input logic [1:0] op, input logic [5:0] r, input logic [63:0] d);
        int n;
        n = 0;
        @(negedge clk_in);
        cop_valid_out = 1'b1;
        cop_op_out = op;
        cop_reg_out = r;
        cop_data_out = d;
        while (!(phase_in === 2'd3 && cop_ready_in === 1'b1) && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        stall_cnt += int'(n >= 100);
        @(negedge clk_in);
        // Released reg and data lines show garbage, never the last value; op lines keep it
        cop_valid_out = 1'b0;
        cop_reg_out = ~cop_reg_out;
        cop_data_out = ~cop_data_out;
    endtask

    task automatic alu_send(input logic [31:0] instr);
        int n;
        n = 0;
        @(negedge clk_in);
        alu_valid_out = 1'b1;
        alu_instr_out = instr;
        while (!(phase_in === 2'd3 && alu_ready_in === 1'b1) && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        stall_cnt += int'(n >= 100);
        @(negedge clk_in);
        alu_valid_out = 1'b0;
        alu_instr_out = ~alu_instr_out;
    endtask
endmodule

/* test/test_fp_coprocessor_datapath.sv */
`timescale 1ns/1ps
module test_fp_coprocessor_datapath;
    logic         clk_in;
    logic         srst_in;
    logic         cop_valid_in;
    logic [1:0]   cop_op_in;
    logic [5:0]   cop_reg_in;
    logic [63:0]  cop_data_in;
    logic         cop_ready_out;
    logic         alu_valid_in;
    logic [31:0]  alu_instr_in;
    logic         alu_ready_out;
    logic [63:0]  rd_data_out;
    logic         rd_valid_out;
    logic [1:0]   phase_out;
    int           error_cnt = 0;
    int           n_tests = 0;
    localparam logic [63:0] ALL = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] HI = 64'hffff_ffff_0000_0000;

    // =========================================
    // Clock, design and host
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    fpcd_core #(.LAT(3)) dut (
        .clk_in(clk_in), .srst_in(srst_in), .cop_valid_in(cop_valid_in),
        .cop_op_in(cop_op_in), .cop_reg_in(cop_reg_in), .cop_data_in(cop_data_in),
        .cop_ready_out(cop_ready_out), .alu_valid_in(alu_valid_in),
        .alu_instr_in(alu_instr_in), .alu_ready_out(alu_ready_out),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .phase_out(phase_out));

    fpcd_host_model host (
        .clk_in(clk_in), .phase_in(phase_out), .cop_ready_in(cop_ready_out),
        .alu_ready_in(alu_ready_out), .cop_valid_out(cop_valid_in), .cop_op_out(cop_op_in),
        .cop_reg_out(cop_reg_in), .cop_data_out(cop_data_in),
        .alu_valid_out(alu_valid_in), .alu_instr_out(alu_instr_in));

    // =========================================
    // Shared helpers
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic store_check(input logic [5:0] r, input logic [63:0] exp,
                               input logic [63:0] mask, output int lat);
        host.cop_send(2'd1, r, 64'h0);
        lat = 0;
        while (rd_valid_out !== 1'b1 && lat < 60)
        begin
            @(negedge clk_in);
            lat++;
        end
        check("store answered", {63'h0, rd_valid_out}, 64'h1);
        check("store data", rd_data_out & mask, exp & mask);
        @(negedge clk_in);
        check("valid pulse", {63'h0, rd_valid_out}, 64'h0);
    endtask

    // Store follows at once, so a missed stall reads a stale register
    task automatic arith(input logic [3:0] op, input logic [5:0] d, input logic [5:0] a,
                         input logic [5:0] b, input logic [63:0] exp, input logic [63:0] mask);
        int lat;
        host.alu_send({op, d, a, b, 10'h000});
        store_check(d, exp, mask, lat);
    endtask

    // =========================================
    // Scenarios
    task automatic test_reset_phase;
        check("phase in reset", {62'h0, phase_out}, 64'h0);
        check("ready in reset", {63'h0, alu_ready_out}, 64'h0);
        srst_in = 1'b0;
        for (int i = 1; i <= 5; i++)
        begin
            @(negedge clk_in);
            check("phase", {62'h0, phase_out}, 64'(i % 4));
        end
        check("alu ready", {63'h0, alu_ready_out}, 64'h1);
        $display("test reset_phase done");
    endtask

    task automatic test_load_store;
        int lat;
        host.cop_send(2'd0, 6'd5, 64'h1234_5678_9abc_def0);
        store_check(6'd5, 64'h1234_5678_9abc_def0, ALL, lat);
        check("store latency", 64'(lat), 64'h4);
        host.cop_send(2'd0, 6'd51, 64'h8000_0000_0000_0001);
        store_check(6'd51, 64'h8000_0000_0000_0001, ALL, lat);
        $display("test load_store done");
    endtask

    task automatic test_transfer;
        int lat;
        host.cop_send(2'd0, 6'd7, ALL);
        host.cop_send(2'd2, 6'd7, 64'haaaa_5555_1111_2222);
        store_check(6'd7, 64'haaaa_5555_0000_0000, ALL, lat);
        store_check(6'd7, 64'haaaa_5555_0000_0000, ALL, lat);
        host.cop_send(2'd0, 6'd7, ALL);
        host.cop_send(2'd3, 6'd7, 64'h0);
        for (lat = 0; rd_valid_out !== 1'b1 && lat < 60; lat++)
        begin
            @(negedge clk_in);
        end
        check("transfer out", rd_data_out, 64'hffff_ffff_0000_0000);
        $display("test transfer done");
    endtask

    task automatic test_refused;
        int seen;
        seen = 0;
        // Watch after each send: an answer to the first would hide inside the second
        for (int i = 0; i < 2; i++)
        begin
            host.cop_send(2'd1, (i == 0) ? 6'd52 : 6'd63, 64'h0);
            repeat (8)
            begin
                @(negedge clk_in);
                seen += int'(rd_valid_out === 1'b1);
            end
        end
        check("foreign store answered", 64'(seen), 64'h0);
        $display("test refused done");
    endtask

    task automatic test_arith;
        host.cop_send(2'd0, 6'd1, 64'h0000_0003_0000_0000);
        host.cop_send(2'd0, 6'd2, 64'h4028_0000_0000_0000);
        arith(4'd0, 6'd10, 6'd54, 6'd54, 64'h4020_0000_0000_0000, ALL);
        arith(4'd1, 6'd11, 6'd54, 6'd54, 64'h0, ALL);
        arith(4'd2, 6'd12, 6'd1, 6'd52, 64'h4028_0000_0000_0000, ALL);
        arith(4'd3, 6'd13, 6'd2, 6'd52, 64'h0000_0003_0000_0000, HI);
        arith(4'd4, 6'd14, 6'd53, 6'd54, 64'h4000_0000_0000_0000, ALL);
        arith(4'd5, 6'd15, 6'd1, 6'd1, 64'h0000_0009_0000_0000, HI);
        arith(4'd6, 6'd16, 6'd54, 6'd54, 64'h4010_0000_0000_0000, ALL);
        arith(4'd7, 6'd17, 6'd53, 6'd52, 64'h4020_0000_0000_0000, 64'hffff_fff0_0000_0000);
        arith(4'd8, 6'd19, 6'd54, 6'd54, 64'h0, ALL);
        host.alu_send({4'd0, 6'd53, 6'd54, 6'd54, 10'h000});
        arith(4'd4, 6'd18, 6'd53, 6'd54, 64'h4000_0000_0000_0000, ALL);
        $display("test arith done");
    endtask

    task automatic test_pipeline;
        time t0;
        int  lat;
        t0 = $time;
        host.alu_send({4'd0, 6'd30, 6'd54, 6'd54, 10'h000});
        t0 = $time;
        host.alu_send({4'd4, 6'd31, 6'd54, 6'd54, 10'h000});
        check("issue spacing", 64'($time - t0), 64'h28);
        fork
            host.alu_send({4'd0, 6'd33, 6'd30, 6'd54, 10'h000});
            host.cop_send(2'd0, 6'd34, 64'h0123_4567_89ab_cdef);
        join
        check("dual issue", 64'($time - t0), 64'h50);
        store_check(6'd30, 64'h4020_0000_0000_0000, ALL, lat);
        store_check(6'd31, 64'h4010_0000_0000_0000, ALL, lat);
        store_check(6'd33, 64'h4028_0000_0000_0000, ALL, lat);
        store_check(6'd34, 64'h0123_4567_89ab_cdef, ALL, lat);
        $display("test pipeline done");
    endtask

    // =========================================
    // Sequence, watchdog and verdict
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        srst_in = 1'b1;
        repeat (6) @(negedge clk_in);
        test_reset_phase();
        test_load_store();
        test_transfer();
        test_refused();
        test_arith();
        test_pipeline();
        check("host stalls", 64'(host.stall_cnt), 64'h0);
        stop_test();
    end

    // Full run needs well under 2000 clocks
    initial
    begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule
